// >>> rtl/mdis_defines.svh
// mdis_defines.svh: reset cause codes, pass counts, timings, script length and widths for the double init sequencer
// assumes: included by bare name from the script rom and init sequencer files
`ifndef MDIS_DEFINES_SVH
`define MDIS_DEFINES_SVH
`define MDIS_CAUSE_POWER_ON 2'h0
`define MDIS_CAUSE_COLD 2'h1
`define MDIS_CAUSE_SOFT_PSC 2'h2
`define MDIS_CAUSE_SOFT_WDT 2'h3
`define MDIS_PASSES_HARD 2'h2
`define MDIS_PASSES_SOFT 2'h1
`define MDIS_PLL_LOCK_NS 20000
`define MDIS_CLK_NS 100
`define MDIS_PLL_LOCK_CYC ((`MDIS_PLL_LOCK_NS + `MDIS_CLK_NS - 1) / `MDIS_CLK_NS)
`define MDIS_CMD_GAP_NS 200
`define MDIS_CMD_GAP_CYC ((`MDIS_CMD_GAP_NS + `MDIS_CLK_NS - 1) / `MDIS_CLK_NS)
`define MDIS_SCRIPT_LEN 8
`define MDIS_CFG_ADDR_W 8
`define MDIS_CFG_DATA_W 32
`endif

// >>> rtl/mdis_pkg.sv
// mdis_pkg.sv: types for the double init sequencer
// assumes: mdis_defines.svh is on the include path
package mdis_pkg;
  typedef enum logic [1:0] {
    mdis_cause_power_on,
    mdis_cause_cold,
    mdis_cause_soft_psc,
    mdis_cause_soft_wdt
  } mdis_cause_t;
  typedef enum logic [2:0] {
    mdis_st_idle,
    mdis_st_pll_cfg,
    mdis_st_pll_wait,
    mdis_st_ctl_cfg,
    mdis_st_ctl_wait,
    mdis_st_pass_done,
    mdis_st_ready
  } mdis_state_t;
  typedef struct packed {
    logic valid;
    logic pll_step;
    logic [7:0] addr;
    logic [31:0] data;
  } mdis_cfg_write_t;
endpackage : mdis_pkg

// >>> rtl/mdis_script_rom.sv
// mdis_script_rom.sv: controller configuration script, registered read
// assumes: single clock, one read per cycle, entries fixed at build time
`include "mdis_defines.svh"
module mdis_script_rom #(
  parameter int DEPTH = `MDIS_SCRIPT_LEN,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic [AW-1:0] rd_idx,
  output logic [`MDIS_CFG_ADDR_W-1:0] rd_addr,
  output logic [`MDIS_CFG_DATA_W-1:0] rd_data
);
  logic [`MDIS_CFG_ADDR_W+`MDIS_CFG_DATA_W-1:0] mem [DEPTH];
  // plain default contents; real timings come from the board build
  for (genvar i = 0; i < DEPTH; i++) begin : g_init
    assign mem[i] = {8'(i * 4), 32'h00000100 + 32'(i)};
  end
  always_ff @(posedge clk) begin
    rd_addr <= mem[rd_idx][`MDIS_CFG_ADDR_W+`MDIS_CFG_DATA_W-1:`MDIS_CFG_DATA_W];
    rd_data <= mem[rd_idx][`MDIS_CFG_DATA_W-1:0];
  end
endmodule : mdis_script_rom

// >>> rtl/mdis_init_seq.sv
// mdis_init_seq.sv: power-up init sequencer for the low power ddr controller
// assumes: one 10 MHz clock, synchronous reset; reset_cause is stable while rst is high
// and is caught on the last reset cycle; cfg_ack acknowledges each write the cycle it is taken
`include "mdis_defines.svh"
module mdis_init_seq #(
  parameter int PLL_LOCK_CYC = `MDIS_PLL_LOCK_CYC,
  parameter int CMD_GAP_CYC = `MDIS_CMD_GAP_CYC,
  parameter int SCRIPT_LEN = `MDIS_SCRIPT_LEN
) (
  input wire logic clk,
  input wire logic rst,
  input wire mdis_pkg::mdis_cause_t reset_cause,
  input wire logic cfg_ack,
  output mdis_pkg::mdis_cfg_write_t cfg_write,
  output logic pll_lock_wait,
  output logic init_busy,
  output logic init_done,
  output logic [1:0] pass_count
);
  localparam int IW = $clog2(SCRIPT_LEN);
  localparam int CW = $clog2(PLL_LOCK_CYC + CMD_GAP_CYC + 1);

  mdis_pkg::mdis_state_t state;
  mdis_pkg::mdis_state_t next_state;
  logic [1:0] passes_needed;
  logic [IW-1:0] step_idx;
  logic [CW-1:0] wait_cnt;
  logic rom_valid;
  logic [`MDIS_CFG_ADDR_W-1:0] rom_addr;
  logic [`MDIS_CFG_DATA_W-1:0] rom_data;

  mdis_script_rom #(
    .DEPTH(SCRIPT_LEN),
    .AW(IW)
  ) u_rom (
    .clk(clk),
    .rd_idx(step_idx),
    .rd_addr(rom_addr),
    .rd_data(rom_data)
  );

  // cause caught while reset is held; no part detection, so every memory sees the same flow
  always_ff @(posedge clk) begin
    if (rst) begin
      case (reset_cause)
        mdis_pkg::mdis_cause_power_on: passes_needed <= `MDIS_PASSES_HARD;
        mdis_pkg::mdis_cause_cold: passes_needed <= `MDIS_PASSES_HARD;
        mdis_pkg::mdis_cause_soft_psc: passes_needed <= `MDIS_PASSES_SOFT;
        mdis_pkg::mdis_cause_soft_wdt: passes_needed <= `MDIS_PASSES_SOFT;
        default: passes_needed <= `MDIS_PASSES_HARD;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      mdis_pkg::mdis_st_idle: next_state = mdis_pkg::mdis_st_pll_cfg;
      mdis_pkg::mdis_st_pll_cfg: begin
        if (cfg_ack) begin
          next_state = mdis_pkg::mdis_st_pll_wait;
        end
      end
      mdis_pkg::mdis_st_pll_wait: begin
        if (wait_cnt == '0) begin
          next_state = mdis_pkg::mdis_st_ctl_cfg;
        end
      end
      mdis_pkg::mdis_st_ctl_cfg: begin
        if (cfg_ack && rom_valid) begin
          next_state = mdis_pkg::mdis_st_ctl_wait;
        end
      end
      mdis_pkg::mdis_st_ctl_wait: begin
        if (wait_cnt == '0) begin
          if (step_idx == IW'(SCRIPT_LEN - 1)) begin
            next_state = mdis_pkg::mdis_st_pass_done;
          end else begin
            next_state = mdis_pkg::mdis_st_ctl_cfg;
          end
        end
      end
      mdis_pkg::mdis_st_pass_done: begin
        // a pass ends here in full before the next may begin
        if (pass_count + 2'h1 >= passes_needed) begin
          next_state = mdis_pkg::mdis_st_ready;
        end else begin
          next_state = mdis_pkg::mdis_st_pll_cfg;
        end
      end
      mdis_pkg::mdis_st_ready: next_state = mdis_pkg::mdis_st_ready;
      default: next_state = mdis_pkg::mdis_st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= mdis_pkg::mdis_st_idle;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pass_count <= 2'h0;
    end else if (state == mdis_pkg::mdis_st_pass_done) begin
      pass_count <= pass_count + 2'h1;
    end
  end

  // step index and rom latency: data valid one cycle after index settles
  always_ff @(posedge clk) begin
    if (rst) begin
      step_idx <= '0;
      rom_valid <= 1'b0;
    end else begin
      rom_valid <= (state == mdis_pkg::mdis_st_ctl_cfg) && !(cfg_ack && rom_valid);
      if (state == mdis_pkg::mdis_st_pll_cfg) begin
        step_idx <= '0;
      end else if (state == mdis_pkg::mdis_st_ctl_wait && wait_cnt == '0) begin
        step_idx <= step_idx + IW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wait_cnt <= '0;
    end else if (state == mdis_pkg::mdis_st_pll_cfg && cfg_ack) begin
      wait_cnt <= CW'(PLL_LOCK_CYC - 1);
    end else if (state == mdis_pkg::mdis_st_ctl_cfg && cfg_ack && rom_valid) begin
      wait_cnt <= CW'(CMD_GAP_CYC - 1);
    end else if (wait_cnt != '0) begin
      wait_cnt <= wait_cnt - CW'(1);
    end
  end

  // write port registered; held until acknowledged
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_write <= '0;
    end else begin
      cfg_write.valid <= (next_state == mdis_pkg::mdis_st_pll_cfg)
        || (state == mdis_pkg::mdis_st_ctl_cfg && rom_valid && !cfg_ack);
      cfg_write.pll_step <= (next_state == mdis_pkg::mdis_st_pll_cfg);
      cfg_write.addr <= (next_state == mdis_pkg::mdis_st_pll_cfg) ? 8'h00 : rom_addr;
      cfg_write.data <= (next_state == mdis_pkg::mdis_st_pll_cfg) ? 32'h00000001 : rom_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pll_lock_wait <= 1'b0;
      init_busy <= 1'b0;
      init_done <= 1'b0;
    end else begin
      pll_lock_wait <= (next_state == mdis_pkg::mdis_st_pll_wait);
      init_busy <= (next_state != mdis_pkg::mdis_st_ready);
      init_done <= (next_state == mdis_pkg::mdis_st_ready);
    end
  end
endmodule : mdis_init_seq

// >>> sim/mdis_init_checker.sv
// port assertions for the init sequencer
// assumes: bound to mdis_init_seq; cause held after reset
module mdis_init_checker (
  input wire logic clk,
  input wire logic rst,
  input wire mdis_pkg::mdis_cause_t reset_cause,
  input wire logic cfg_ack,
  input wire mdis_pkg::mdis_cfg_write_t cfg_write,
  input wire logic pll_lock_wait,
  input wire logic init_busy,
  input wire logic init_done,
  input wire logic [1:0] pass_count
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // soft causes have bit 1 set
  logic [1:0] want;
  assign want = reset_cause[1] ? 2'h1 : 2'h2;
  property p_go; $fell(rst) |=> cfg_write.valid && cfg_write.pll_step && init_busy; endproperty
  a_go: assert property (p_go) else $error("no pll write");
  property p_hold; cfg_write.valid && !cfg_ack |=> $stable(cfg_write); endproperty
  a_hold: assert property (p_hold) else $error("write moved");
  property p_pll; cfg_write.valid && cfg_write.pll_step && cfg_ack |=> pll_lock_wait && !cfg_write.valid; endproperty
  a_pll: assert property (p_pll) else $error("no lock wait");
  property p_quiet; pll_lock_wait |-> !cfg_write.valid; endproperty
  a_quiet: assert property (p_quiet) else $error("write in lock");
  property p_step; $changed(pass_count) |-> pass_count == $past(pass_count) + 2'h1; endproperty
  a_step: assert property (p_step) else $error("pass skip");
  property p_done; init_done |-> !init_busy && !cfg_write.valid && pass_count == want; endproperty
  a_done: assert property (p_done) else $error("pass count");
  property p_stay; init_done |=> init_done && $stable(pass_count); endproperty
  a_stay: assert property (p_stay) else $error("done lost");
  property p_early; pass_count == 2'h1 && !reset_cause[1] |-> !init_done; endproperty
  a_early: assert property (p_early) else $error("one pass");
  c_two: cover property (init_done && pass_count == 2'h2);
  c_one: cover property (init_done && pass_count == 2'h1);
  c_stall: cover property (cfg_write.valid && !cfg_ack ##1 cfg_ack);
endmodule : mdis_init_checker
bind mdis_init_seq mdis_init_checker u_chk (.clk, .rst, .reset_cause, .cfg_ack, .cfg_write, .pll_lock_wait,
  .init_busy, .init_done, .pass_count);

// >>> sim/mdis_mem_model.sv
// behavioural mobile ddr memory on the config port
// assumes: acks an offered write after delay cycles
module mdis_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire mdis_pkg::mdis_cfg_write_t cfg_write,
  input wire logic [3:0] delay,
  output logic cfg_ack = 1'b0,
  output int pll_cnt,
  output int ctl_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int age = 0;
  // a slow memory still answers, so the sequencer must hold its write
  always @(negedge clk) begin
    cfg_ack <= cfg_write.valid && age >= delay;
    age <= cfg_write.valid ? age + 1 : 0;
  end
  always @(posedge clk) begin
    if (rst) begin
      pll_cnt <= 0;
      ctl_cnt <= 0;
    end else if (cfg_write.valid && cfg_ack) begin
      pll_cnt <= pll_cnt + cfg_write.pll_step;
      ctl_cnt <= ctl_cnt + !cfg_write.pll_step;
    end
  end
endmodule : mdis_mem_model

// >>> sim/mdis_init_seq_test.sv
// self-checking bench for the double init sequencer
// assumes: memory model on the config port, pll lock cut to 3 cycles
module mdis_init_seq_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] cause = 2'h0;
  logic [3:0] delay = 4'h0;
  logic cfg_ack, pll_lock_wait, init_busy, init_done;
  logic [1:0] pass_count;
  mdis_pkg::mdis_cfg_write_t cfg_write;
  int pll_cnt, ctl_cnt;
  int error_cnt = 0;
  int compares = 0;
  always #50 clk = ~clk;
  mdis_init_seq #(.PLL_LOCK_CYC(3)) u_dut (.clk, .rst, .reset_cause(mdis_pkg::mdis_cause_t'(cause)), .cfg_ack,
    .cfg_write, .pll_lock_wait, .init_busy, .init_done, .pass_count);
  mdis_mem_model u_mem (.clk, .rst, .cfg_write, .delay, .cfg_ack, .pll_cnt, .ctl_cnt);
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task stop_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task do_reset(input logic [1:0] c, input logic [3:0] d);
    @(negedge clk);
    rst = 1'b1;
    cause = c;
    delay = d;
    repeat (20) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset
  // bounded wait; a hang ends the run instead of stalling it
  task wait_pass(input logic [1:0] n);
    int i;
    for (i = 0; i < 1000 && pass_count !== n; i++) @(negedge clk);
    if (i == 1000) begin
      check(32'h0, 32'h1);
      stop_test();
    end
  endtask : wait_pass
  task finish_run(input logic [1:0] n);
    wait_pass(n);
    repeat (2) @(negedge clk);
    check(init_done, 32'h1);
    check(init_busy, 32'h0);
    check(pass_count, n);
    check(pll_cnt, n);
    check(ctl_cnt, 32'h8 * n);
  endtask : finish_run
  task t_hard(input logic [1:0] c, input logic [3:0] d);
    do_reset(c, d);
    wait_pass(2'h1);
    repeat (4) @(negedge clk);
    check(init_done, 32'h0);
    check(init_busy, 32'h1);
    finish_run(2'h2);
  endtask : t_hard
  task t_soft();
    do_reset(2'h2, 4'h2);
    finish_run(2'h1);
    do_reset(2'h3, 4'h0);
    // zero delay: pll write taken at the second edge, lock wait shows after it
    repeat (2) @(negedge clk);
    check(pll_lock_wait, 32'h1);
    finish_run(2'h1);
    repeat (30) @(negedge clk);
    check(pll_cnt, 32'h1);
  endtask : t_soft
  task t_mid_reset();
    do_reset(2'h1, 4'h1);
    wait_pass(2'h1);
    do_reset(2'h3, 4'h1);
    finish_run(2'h1);
  endtask : t_mid_reset
  initial begin
    t_hard(2'h0, 4'h0);
    t_hard(2'h1, 4'h5);
    t_soft();
    t_mid_reset();
    stop_test();
  end
endmodule : mdis_init_seq_test
